/* File: shared/sup_pkg.sv */
package sup_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets on the Wishbone slave
	localparam logic [7:0] SUP_REG_CTRL = 8'h00;
	localparam logic [7:0] SUP_REG_CMD = 8'h04;
	localparam logic [7:0] SUP_REG_ARG0 = 8'h08;
	localparam logic [7:0] SUP_REG_ARG1 = 8'h0c;
	localparam logic [7:0] SUP_REG_ARG2 = 8'h10;
	localparam logic [7:0] SUP_REG_RESP = 8'h14;
	localparam logic [7:0] SUP_REG_RDATA = 8'h18;
	localparam logic [7:0] SUP_REG_SCAN = 8'h1c;
	localparam logic [7:0] SUP_REG_SET = 8'h20;

	// Control register fields
	localparam int SUP_CTRL_CMD_MODE = 0;
	localparam int SUP_CTRL_RESTART = 1;

	// Settings readback fields
	localparam int SUP_SET_Z_ONLY = 0;
	localparam int SUP_SET_PAUSE_LO = 1;
	localparam int SUP_SET_MEDIAN = 5;

	////////////////////////////////////////////////////////////////////////
	// Command and answer codes
	localparam logic [15:0] SUP_CMD_SET_SCAN = 16'h0053;
	localparam logic [15:0] SUP_CMD_SET_PARAM = 16'h0059;
	localparam logic [15:0] SUP_CMD_GET_PARAM = 16'h005b;
	localparam logic [15:0] SUP_RSP_PARAM = 16'h005c;
	localparam logic [15:0] SUP_RSP_ACK = 16'h4141;
	localparam logic [15:0] SUP_RSP_NAK = 16'h414e;
	localparam logic [15:0] SUP_RSP_NONE = 16'h0000;

	// Parameter identifiers
	localparam logic [15:0] SUP_ID_X_OUTPUT = 16'h07d4;
	localparam logic [15:0] SUP_ID_PAUSE = 16'h07d8;
	localparam logic [15:0] SUP_ID_MEDIAN = 16'h07db;

	// Field positions inside the argument words
	localparam int SUP_PERSIST_BIT = 0;
	localparam int SUP_FLAG_BIT = 0;
	localparam int SUP_PAUSE_W = 4;
	localparam logic [3:0] SUP_PAUSE_MAX = 4'h9;

	////////////////////////////////////////////////////////////////////////
	// Values after reset (factory settings)
	localparam logic [15:0] SUP_SCAN_RST = 16'h0000;
	localparam logic [3:0] SUP_PAUSE_RST = 4'h0;

	////////////////////////////////////////////////////////////////////////
	// Timing: clock period and pause step
	localparam int SUP_CLK_PERIOD_NS = 8;
	localparam int SUP_PAUSE_STEP_US = 100;
	localparam int SUP_PAUSE_STEP_CYC = SUP_PAUSE_STEP_US * 1000
		/ SUP_CLK_PERIOD_NS;
	localparam int SUP_PAUSE_STEPS_MAX = 10;

	////////////////////////////////////////////////////////////////////////
	// User settings that travel together
	typedef struct packed {
		logic median_enable_flag;
		logic [3:0] pause_code_bits;
		logic z_only_flag;
	} sup_set_s;

	localparam sup_set_s SUP_SET_RST = '{
		median_enable_flag: 1'b0,
		pause_code_bits: SUP_PAUSE_RST,
		z_only_flag: 1'b0
	};

	// Packet sequencer states
	typedef enum logic {
		SUP_SEQ_IDLE = 1'b0,
		SUP_SEQ_PAUSE = 1'b1
	} sup_seq_e;

endpackage

/* File: src/sup_median3.sv */
`timescale 1ns/10ps
`default_nettype none
module sup_median3
	import sup_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Synchronous reset
	input wire logic enable_i, // Filter on
	input wire logic valid_i, // Sample strobe
	input wire logic [WIDTH-1:0] z_i, // Raw Z sample
	output logic valid_o, // Output strobe
	output logic [WIDTH-1:0] z_o // Filtered Z sample
);

	if (WIDTH < 1) begin : g_chk
		$error("WIDTH must be at least one");
	end

	typedef struct packed {
		logic [WIDTH-1:0] d1;
		logic [WIDTH-1:0] d2;
		logic [WIDTH-1:0] z;
		logic valid;
	} sup_med_s;

	sup_med_s r;
	sup_med_s next_r;

	// Median of three keeps a step but drops a single-sample spike
	function automatic logic [WIDTH-1:0] med3(input logic [WIDTH-1:0] a,
		input logic [WIDTH-1:0] b, input logic [WIDTH-1:0] c);
		logic [WIDTH-1:0] lo;
		logic [WIDTH-1:0] hi;
		lo = (a < b) ? a : b;
		hi = (a < b) ? b : a;
		med3 = (c < lo) ? lo : ((c > hi) ? hi : c);
	endfunction

	// Shift window and pick output
	always_comb begin
		next_r = r;
		next_r.valid = valid_i;
		if (valid_i) begin
			next_r.d1 = z_i;
			next_r.d2 = r.d1;
			next_r.z = enable_i ? med3(z_i, r.d1, r.d2) : z_i;
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign valid_o = r.valid;
	assign z_o = r.z;

endmodule // sup_median3
`default_nettype wire

/* File: src/sup_cmd_top.sv */
`timescale 1ns/10ps
`default_nettype none
module sup_cmd_top
	import sup_pkg::*;
#(
	parameter int PAUSE_STEP_CYC = SUP_PAUSE_STEP_CYC,
	parameter int Z_WIDTH = 16
) (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Synchronous reset, power-on
	input wire logic cyc_i, // Wishbone cycle
	input wire logic stb_i, // Wishbone strobe
	input wire logic we_i, // Wishbone write
	input wire logic [7:0] adr_i, // Byte address
	input wire logic [3:0] sel_i, // Byte lanes
	input wire logic [31:0] dat_i, // Write data
	output logic [31:0] dat_o, // Read data
	output logic ack_o, // Wishbone acknowledge
	input wire logic z_pkt_done_i, // Z packet sent
	input wire logic cascade_req_i, // Cascade pulse from scan logic
	input wire logic z_valid_i, // Raw Z sample strobe
	input wire logic [Z_WIDTH-1:0] z_i, // Raw Z sample
	output logic measuring_o, // Measure mode active
	output logic cascade_o, // Cascading output
	output logic x_pkt_go_o, // Start X packet
	output logic z_only_o, // Send Z packets only
	output logic [15:0] scan_number_o, // Scan number for protocol
	output logic z_valid_o, // Filtered Z strobe
	output logic [Z_WIDTH-1:0] z_o // Filtered Z sample
);

	localparam int CW = 20;

	if (PAUSE_STEP_CYC < 1 ||
		PAUSE_STEP_CYC * SUP_PAUSE_STEPS_MAX >= (1 << CW)) begin : g_chk
		$error("PAUSE_STEP_CYC out of range for the pause counter");
	end

	localparam logic [CW-1:0] STEP = CW'(PAUSE_STEP_CYC);

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic cmd_mode;
		logic meas;
		logic [15:0] arg0;
		logic [15:0] arg1;
		logic [15:0] arg2;
		logic [15:0] resp_code;
		logic [15:0] resp_data;
		logic [15:0] scan;
		sup_set_s live;
		sup_set_s saved;
		sup_seq_e seq;
		logic [CW-1:0] cnt;
		logic x_go;
		logic casc;
	} sup_state_s;

	sup_state_s r;
	sup_state_s next_r;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Merge the low two byte lanes into a 16-bit word
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] sel);
		logic [15:0] m;
		m = old;
		if (sel[0]) begin
			m[7:0] = wd[7:0];
		end
		if (sel[1]) begin
			m[15:8] = wd[15:8];
		end
		merge16 = m;
	endfunction

	// Pause length in cycles for a code 0..9
	function automatic logic [CW-1:0] pause_len(input logic [3:0] code);
		logic [CW-1:0] n;
		n = STEP;
		for (int i = 0; i < SUP_PAUSE_STEPS_MAX - 1; i++) begin
			if (4'(i) < code) begin
				n = n + STEP;
			end
		end
		pause_len = n;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next-state logic: bus slave, command decode, packet sequencer
	always_comb begin
		logic req;
		logic wr;
		logic [15:0] code;
		logic [15:0] cmd;
		sup_set_s nset;
		sup_set_s nsav;
		logic ok;
		req = 1'b0;
		wr = 1'b0;
		code = SUP_RSP_NONE;
		cmd = 16'h0000;
		nset = r.live;
		// Saved copy moves per field, so an earlier unsaved change stays volatile
		nsav = r.saved;
		ok = 1'b0;
		next_r = r;
		next_r.x_go = 1'b0;

		// Answer a request one cycle after it appears, drop ack after
		req = cyc_i && stb_i && !r.ack;
		wr = req && we_i;
		next_r.ack = req;
		next_r.rdata = 32'h0000_0000;

		// Read mux; unmapped addresses read zero
		if (req && !we_i) begin
			unique case (adr_i)
				SUP_REG_CTRL: begin
					next_r.rdata[SUP_CTRL_CMD_MODE] = r.cmd_mode;
				end
				SUP_REG_ARG0: next_r.rdata[15:0] = r.arg0;
				SUP_REG_ARG1: next_r.rdata[15:0] = r.arg1;
				SUP_REG_ARG2: next_r.rdata[15:0] = r.arg2;
				SUP_REG_RESP: next_r.rdata[15:0] = r.resp_code;
				SUP_REG_RDATA: next_r.rdata[15:0] = r.resp_data;
				SUP_REG_SCAN: next_r.rdata[15:0] = r.scan;
				SUP_REG_SET: begin
					next_r.rdata[SUP_SET_MEDIAN:SUP_SET_Z_ONLY] = r.live;
				end
				default: next_r.rdata = 32'h0000_0000;
			endcase
		end

		// Plain register writes
		if (wr) begin
			unique case (adr_i)
				SUP_REG_CTRL: begin
					if (sel_i[0]) begin
						next_r.cmd_mode = dat_i[SUP_CTRL_CMD_MODE];
						if (dat_i[SUP_CTRL_RESTART]) begin
							next_r.live = r.saved;
						end
					end
				end
				SUP_REG_ARG0: next_r.arg0 = merge16(r.arg0, dat_i, sel_i);
				SUP_REG_ARG1: next_r.arg1 = merge16(r.arg1, dat_i, sel_i);
				SUP_REG_ARG2: next_r.arg2 = merge16(r.arg2, dat_i, sel_i);
				default: begin
				end
			endcase
		end

		// Command execution on a write of the command code
		if (wr && adr_i == SUP_REG_CMD) begin
			cmd = merge16(16'h0000, dat_i, sel_i);
			next_r.resp_data = 16'h0000;
			if (!r.cmd_mode) begin
				code = SUP_RSP_NAK;
			end else if (cmd == SUP_CMD_SET_SCAN) begin
				next_r.scan = r.arg0;
				code = SUP_RSP_ACK;
			end else if (cmd == SUP_CMD_SET_PARAM) begin
				ok = 1'b1;
				unique case (r.arg1)
					SUP_ID_X_OUTPUT: begin
						nset.z_only_flag = r.arg2[SUP_FLAG_BIT];
						nsav.z_only_flag = r.arg2[SUP_FLAG_BIT];
					end
					SUP_ID_PAUSE: begin
						if (r.arg2[SUP_PAUSE_W-1:0] > SUP_PAUSE_MAX) begin
							ok = 1'b0;
						end else begin
							nset.pause_code_bits =
								r.arg2[SUP_PAUSE_W-1:0];
							nsav.pause_code_bits = r.arg2[SUP_PAUSE_W-1:0];
						end
					end
					SUP_ID_MEDIAN: begin
						nset.median_enable_flag = r.arg2[SUP_FLAG_BIT];
						nsav.median_enable_flag = r.arg2[SUP_FLAG_BIT];
					end
					default: ok = 1'b0;
				endcase
				if (ok) begin
					next_r.live = nset;
					if (r.arg0[SUP_PERSIST_BIT]) begin
						// Only the field this command names is made persistent
						next_r.saved = nsav;
					end
					code = SUP_RSP_ACK;
				end else begin
					code = SUP_RSP_NAK;
				end
			end else if (cmd == SUP_CMD_GET_PARAM) begin
				code = SUP_RSP_PARAM;
				unique case (r.arg0)
					SUP_ID_X_OUTPUT: begin
						next_r.resp_data[SUP_FLAG_BIT] =
							r.live.z_only_flag;
					end
					SUP_ID_PAUSE: begin
						next_r.resp_data[SUP_PAUSE_W-1:0] =
							r.live.pause_code_bits;
					end
					SUP_ID_MEDIAN: begin
						next_r.resp_data[SUP_FLAG_BIT] =
							r.live.median_enable_flag;
					end
					default: code = SUP_RSP_NAK;
				endcase
			end else begin
				code = SUP_RSP_NAK;
			end
			next_r.resp_code = code;
		end

		// Cascading output only in measure mode
		next_r.casc = cascade_req_i && !r.cmd_mode;

		// Measure-mode flag kept as its own flop so the output is registered
		next_r.meas = !next_r.cmd_mode;

		// Z-to-X pause, then start the X packet unless Z only
		unique case (r.seq)
			SUP_SEQ_IDLE: begin
				if (z_pkt_done_i && !r.cmd_mode &&
					!r.live.z_only_flag) begin
					next_r.seq = SUP_SEQ_PAUSE;
					next_r.cnt = pause_len(r.live.pause_code_bits);
				end
			end
			SUP_SEQ_PAUSE: begin
				if (r.cmd_mode) begin
					next_r.seq = SUP_SEQ_IDLE;
					next_r.cnt = '0;
				end else if (r.cnt <= CW'(1)) begin
					next_r.seq = SUP_SEQ_IDLE;
					next_r.cnt = '0;
					next_r.x_go = 1'b1;
				end else begin
					next_r.cnt = r.cnt - CW'(1);
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '{
				ack: 1'b0,
				rdata: 32'h0000_0000,
				cmd_mode: 1'b0,
				meas: 1'b1,
				arg0: 16'h0000,
				arg1: 16'h0000,
				arg2: 16'h0000,
				resp_code: SUP_RSP_NONE,
				resp_data: 16'h0000,
				scan: SUP_SCAN_RST,
				live: SUP_SET_RST,
				saved: SUP_SET_RST,
				seq: SUP_SEQ_IDLE,
				cnt: '0,
				x_go: 1'b0,
				casc: 1'b0
			};
		end else begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Median filter on the Z stream
	sup_median3 #(
		.WIDTH(Z_WIDTH)
	) u_median (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.enable_i(r.live.median_enable_flag),
		.valid_i(z_valid_i && !r.cmd_mode),
		.z_i(z_i),
		.valid_o(z_valid_o),
		.z_o(z_o)
	);

	// Outputs straight from the state register
	assign dat_o = r.rdata;
	assign ack_o = r.ack;
	assign measuring_o = r.meas;
	assign cascade_o = r.casc;
	assign x_pkt_go_o = r.x_go;
	assign z_only_o = r.live.z_only_flag;
	assign scan_number_o = r.scan;

endmodule // sup_cmd_top
`default_nettype wire

/* File: tb/sup_cmd_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module sup_cmd_properties
	import sup_pkg::*;
(
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Reset
	input wire logic cyc_i, // Cycle
	input wire logic stb_i, // Strobe
	input wire logic ack_o, // Ack
	input wire logic [31:0] dat_o, // Read data
	input wire logic cascade_req_i, // Cascade request
	input wire logic z_valid_i, // Raw strobe
	input wire logic measuring_o, // Measure mode
	input wire logic cascade_o, // Cascade out
	input wire logic x_pkt_go_o, // X packet start
	input wire logic z_only_o, // Z only
	input wire logic [15:0] scan_number_o, // Scan number
	input wire logic z_valid_o // Filtered strobe
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	//////////////////////////////////////////////////
	// Bus answer shape
	ack_next_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("no ack after request");
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
		else $error("read data outside ack");
	// Settings move only on an answered access
	scan_on_ack_a: assert property (!$stable(scan_number_o) |-> ack_o)
		else $error("scan number moved without access");
	zonly_on_ack_a: assert property (!$stable(z_only_o) |-> ack_o)
		else $error("output flag moved without access");
	// Command mode silences cascade, packets and samples
	casc_off_a: assert property (
		!measuring_o && $past(!measuring_o) |-> !cascade_o)
		else $error("cascade active in command mode");
	casc_follow_a: assert property (
		measuring_o && $past(measuring_o) && !$past(rst_i)
		|-> cascade_o == $past(cascade_req_i))
		else $error("cascade not following request");
	go_off_a: assert property (
		!measuring_o && $past(!measuring_o) |-> !x_pkt_go_o)
		else $error("packet start in command mode");
	go_pulse_a: assert property (x_pkt_go_o |=> !x_pkt_go_o)
		else $error("packet start longer than a cycle");
	zv_gate_a: assert property (
		$past(z_valid_i) |-> z_valid_o == $past(measuring_o))
		else $error("sample strobe wrongly gated");
endmodule // sup_cmd_properties
bind sup_cmd_top sup_cmd_properties u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .dat_o(dat_o),
	.cascade_req_i(cascade_req_i), .z_valid_i(z_valid_i),
	.measuring_o(measuring_o), .cascade_o(cascade_o),
	.x_pkt_go_o(x_pkt_go_o), .z_only_o(z_only_o),
	.scan_number_o(scan_number_o), .z_valid_o(z_valid_o));
`default_nettype wire

/* File: tb/sup_pkt_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sup_pkt_model (
	input wire logic clk_i, // Clock
	output logic done_o, // Z packet sent
	output logic casc_o, // Cascade request
	output logic zv_o, // Sample strobe
	output logic [15:0] z_o // Raw sample
);
	// Idle levels; cascade request held up so gating shows
	initial begin
		done_o = 1'b0;
		casc_o = 1'b1;
		zv_o = 1'b0;
		z_o = 16'h0;
	end
	//////////////////////////////////////////////////
	// One-cycle end-of-packet pulse
	task automatic done_pulse();
		@(posedge clk_i);
		done_o <= 1'b1;
		@(posedge clk_i);
		done_o <= 1'b0;
	endtask
	// One sample; the released bus shows the inverse
	task automatic sample(input logic [15:0] v);
		@(posedge clk_i);
		zv_o <= 1'b1;
		z_o <= v;
		@(posedge clk_i);
		zv_o <= 1'b0;
		z_o <= ~v;
	endtask
endmodule // sup_pkt_model
`default_nettype wire

/* File: tb/sup_cmd_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module sup_cmd_tb_top
	import sup_pkg::*;
;
	logic clk_i, rst_i, req, we_i, ack_o, done, cr, zv, meas, casc, go;
	logic zonly, zvo;
	logic [7:0] adr_i;
	logic [3:0] sel_i, lanes;
	logic [31:0] dat_i, dat_o, rd;
	logic [15:0] z, zo, scan;
	logic [15:0] ids [4] = '{SUP_ID_PAUSE, SUP_ID_PAUSE, SUP_ID_MEDIAN,
		16'h07d5};
	logic [15:0] vals [4] = '{16'h9, 16'ha, 16'h1, 16'h1};
	logic [15:0] exps [4] = '{SUP_RSP_ACK, SUP_RSP_NAK, SUP_RSP_ACK,
		SUP_RSP_NAK};
	int n_errors, check_count, n;
	//////////////////////////////////////////////////
	// Block under test and the packet side
	sup_cmd_top #(.PAUSE_STEP_CYC(4)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(req), .stb_i(req), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.z_pkt_done_i(done), .cascade_req_i(cr), .z_valid_i(zv),
		.z_i(z), .measuring_o(meas), .cascade_o(casc), .x_pkt_go_o(go),
		.z_only_o(zonly), .scan_number_o(scan), .z_valid_o(zvo), .z_o(zo));
	sup_pkt_model pm (.clk_i(clk_i), .done_o(done), .casc_o(cr),
		.zv_o(zv), .z_o(z));
	// Clock and watchdog
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	initial begin
		repeat (5000) @(posedge clk_i);
		n_errors++;
		results();
	end
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One classic bus cycle; read data lands in rd
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		req <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= lanes;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o;
		req <= 1'b0;
	endtask
	// Arguments, code, then the answer code into rd
	task automatic cmd(input logic [15:0] c, a0, a1, a2);
		wb(1'b1, SUP_REG_ARG0, {16'h0, a0});
		wb(1'b1, SUP_REG_ARG1, {16'h0, a1});
		wb(1'b1, SUP_REG_ARG2, {16'h0, a2});
		wb(1'b1, SUP_REG_CMD, {16'h0, c});
		wb(1'b0, SUP_REG_RESP, 32'h0);
	endtask
	task automatic results();
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	//////////////////////////////////////////////////
	// Main sequence
	initial begin
		rst_i = 1'b1;
		req = 1'b0;
		we_i = 1'b0;
		adr_i = 8'h0;
		sel_i = 4'h0;
		lanes = 4'hf;
		dat_i = 32'h0;
		n_errors = 0;
		check_count = 0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		chk({15'h0, meas, scan}, 32'h10000);
		wb(1'b0, SUP_REG_SET, 32'h0);
		chk(rd, 32'h0);
		cmd(SUP_CMD_SET_SCAN, 16'h1234, 16'h0, 16'h0);
		chk(rd, {16'h0, SUP_RSP_NAK});
		wb(1'b1, SUP_REG_CTRL, 32'h1);
		cmd(SUP_CMD_SET_SCAN, 16'hbeef, 16'h0, 16'h0);
		chk(rd, {16'h0, SUP_RSP_ACK});
		chk({14'h0, casc, meas, scan}, 32'hbeef);
		cmd(SUP_CMD_SET_PARAM, 16'h0, SUP_ID_X_OUTPUT, 16'h1);
		chk({15'h0, zonly, rd[15:0]}, {16'h1, SUP_RSP_ACK});
		cmd(SUP_CMD_GET_PARAM, SUP_ID_X_OUTPUT, 16'h0, 16'h0);
		chk(rd, {16'h0, SUP_RSP_PARAM});
		wb(1'b0, SUP_REG_RDATA, 32'h0);
		chk({31'h0, rd[0]}, 32'h1);
		// Saved settings, a bad pause code, an unknown identifier
		for (int i = 0; i < 4; i++) begin
			cmd(SUP_CMD_SET_PARAM, 16'h1, ids[i], vals[i]);
			chk(rd, {16'h0, exps[i]});
		end
		cmd(SUP_CMD_GET_PARAM, SUP_ID_PAUSE, 16'h0, 16'h0);
		wb(1'b0, SUP_REG_RDATA, 32'h0);
		chk({28'h0, rd[3:0]}, 32'h9);
		// Restart keeps saved values and drops the unsaved flag
		wb(1'b1, SUP_REG_CTRL, 32'h3);
		wb(1'b0, SUP_REG_SET, 32'h0);
		chk(rd, 32'h32);
		wb(1'b0, 8'hfc, 32'h0);
		chk(rd, 32'h0);
		// Only lane 0 written: high byte and upper lanes left alone
		lanes = 4'h1;
		wb(1'b1, SUP_REG_ARG0, 32'hffff_abcd);
		lanes = 4'hf;
		wb(1'b0, SUP_REG_ARG0, 32'h0);
		chk(rd, 32'h0000_07cd);
		// Measure mode: time the Z to X pause at code nine
		wb(1'b1, SUP_REG_CTRL, 32'h0);
		pm.done_pulse();
		n = 0;
		do begin
			@(posedge clk_i);
			#1;
			n++;
		end while (go !== 1'b1 && n < 100);
		chk(32'(n), 32'h28);
		// Median of a spike keeps the level
		pm.sample(16'h0005);
		pm.sample(16'h0005);
		pm.sample(16'h0100);
		#1;
		chk({15'h0, zvo, zo}, 32'h10005);
		pm.sample(16'h0007);
		#1;
		chk({15'h0, zvo, zo}, 32'h10007);
		results();
	end
endmodule // sup_cmd_tb_top
`default_nettype wire
